// ==== two_wire_unit_pkg.sv ====
// Shared constants and types for the two-wire bus master
package two_wire_unit_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 5;
   localparam int BIT_TIME_NS = 10000;
   localparam int QUARTER_CYC = BIT_TIME_NS / (4 * CLK_PERIOD_NS);

   // ==========================================================
   // Byte framing
   // ==========================================================
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [1:0] INT_ADDR_NONE = 2'h0;

   // Kind of byte being moved
   localparam logic [1:0] K_ADDR = 2'h0;
   localparam logic [1:0] K_INT = 2'h1;
   localparam logic [1:0] K_DATA = 2'h2;

   // Quarter phases of one bit slot
   localparam logic [1:0] Q_SETUP = 2'h0;
   localparam logic [1:0] Q_RISE = 2'h1;
   localparam logic [1:0] Q_HIGH = 2'h2;
   localparam logic [1:0] Q_FALL = 2'h3;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic RST_FLAG = 1'b0;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [7:0] RST_BYTE = 8'h00;

   typedef enum logic [5:0] {
      s_idle = 6'h01,
      s_start = 6'h02,
      s_bit = 6'h04,
      s_hold = 6'h08,
      s_stop = 6'h10,
      s_lost = 6'h20
   } state_t;

endpackage : two_wire_unit_pkg

// ==== line_sync.sv ====
// Two-stage synchroniser for the sampled bus lines
`timescale 1ns/1ps
module line_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Lines
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage1_q <= {WIDTH{two_wire_unit_pkg::LINE_IDLE}};
         stage2_q <= {WIDTH{two_wire_unit_pkg::LINE_IDLE}};
      end else begin
         stage1_q <= async_in;
         stage2_q <= stage1_q;
      end
   end

   assign sync_out = stage2_q;

endmodule : line_sync

// ==== two_wire_unit_master.sv ====
// Two-wire bus master with internal address, quick command and arbitration
`timescale 1ns/1ps
module two_wire_unit_master #(
   parameter int QUARTER_CYC = two_wire_unit_pkg::QUARTER_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Configuration
   input wire logic master_enable,
   input wire logic [6:0] target_device_address,
   input wire logic [1:0] internal_address_size,
   input wire logic [23:0] internal_address_bytes,
   input wire logic master_direction_bit,
   // Commands
   input wire logic start_cmd,
   input wire logic stop_cmd,
   input wire logic quick_cmd,
   input wire logic thr_write,
   input wire logic [7:0] thr_data,
   input wire logic rhr_read,
   input wire logic status_read,
   // Status
   output logic [7:0] rhr_data,
   output logic transmission_complete_flag,
   output logic transmit_ready_flag,
   output logic receive_ready_flag,
   output logic no_acknowledge_flag,
   output logic arbitration_lost_flag,
   // Bus pins
   input wire logic serial_clock_line_in,
   output logic serial_clock_line_out,
   output logic serial_clock_line_oe,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe
);

   localparam int DIV_W = $clog2(QUARTER_CYC);

   // ==========================================================
   // Line synchronisation and bus monitor
   // ==========================================================
   logic [1:0] lines_s;
   logic scl_s;
   logic sda_s;
   logic sda_prev_q;
   logic bus_busy_q;
   logic start_det;
   logic stop_det;

   line_sync #(.WIDTH(2)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in({serial_clock_line_in, serial_data_line_in}),
      .sync_out(lines_s)
   );

   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];
   assign start_det = scl_s && sda_prev_q && !sda_s;
   assign stop_det = scl_s && !sda_prev_q && sda_s;

   // Busy state stays internal
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sda_prev_q <= two_wire_unit_pkg::LINE_IDLE;
         bus_busy_q <= two_wire_unit_pkg::RST_FLAG;
      end else begin
         sda_prev_q <= sda_s;
         if (start_det) begin
            bus_busy_q <= 1'b1;
         end else if (stop_det) begin
            bus_busy_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Quarter-bit timebase
   // ==========================================================
   logic [DIV_W-1:0] div_q;
   logic tick;
   logic need_high;
   logic adv;
   two_wire_unit_pkg::state_t st_q;
   two_wire_unit_pkg::state_t st_d;
   logic [1:0] qc_q;
   logic [1:0] qc_d;

   assign tick = (div_q == DIV_W'(QUARTER_CYC - 1));
   assign need_high = (qc_q == two_wire_unit_pkg::Q_HIGH) &&
      (st_q == two_wire_unit_pkg::s_start || st_q == two_wire_unit_pkg::s_bit ||
       st_q == two_wire_unit_pkg::s_stop);
   // A slave holding the clock low stretches the high quarter
   assign adv = tick && !(need_high && !scl_s);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + 1'b1;
      end
   end

   // ==========================================================
   // Byte sources
   // ==========================================================
   function automatic logic [7:0] int_addr_pick(input logic [1:0] left,
                                                input logic [23:0] bytes);
      case (left)
         2'h3: int_addr_pick = bytes[23:16];
         2'h2: int_addr_pick = bytes[15:8];
         default: int_addr_pick = bytes[7:0];
      endcase
   endfunction : int_addr_pick

   logic [7:0] sh_q, sh_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] kind_q, kind_d;
   logic [1:0] int_left_q, int_left_d;
   logic rs_done_q, rs_done_d;
   logic wire_rd_q, wire_rd_d;
   logic nacked_q, nacked_d;
   logic scl_low_q, scl_low_d;
   logic sda_low_q, sda_low_d;
   logic req_q, quick_q, stop_req_q;
   logic thr_full_q, rhr_full_q, noack_q, arb_q, cmpl_q;
   logic [7:0] thr_q;
   logic [7:0] rhr_q;
   logic has_int;
   logic dir_bit;
   logic [7:0] addr_byte;
   logic rd_byte;
   logic accept;
   logic start_evt;
   logic end_evt;
   logic lost_evt, no_acknowledge_flag_set, rx_done, ack_end, thr_load;

   assign has_int = (internal_address_size != two_wire_unit_pkg::INT_ADDR_NONE);
   // Write phase first when an internal address is still to go
   assign dir_bit = quick_q ? master_direction_bit :
      (has_int && !rs_done_q) ? 1'b0 : master_direction_bit;
   assign addr_byte = {target_device_address, dir_bit};
   assign rd_byte = (kind_q == two_wire_unit_pkg::K_DATA) && wire_rd_q;
   assign accept = (st_q == two_wire_unit_pkg::s_idle) && req_q &&
      master_enable && !bus_busy_q;
   assign start_evt = master_enable && (start_cmd || quick_cmd ||
      (thr_write && !master_direction_bit && st_q == two_wire_unit_pkg::s_idle &&
       !req_q));
   assign end_evt = (st_q == two_wire_unit_pkg::s_stop && adv &&
      qc_q == two_wire_unit_pkg::Q_FALL) ||
      (st_q == two_wire_unit_pkg::s_lost && stop_det);

   // ==========================================================
   // Transfer sequencer
   // ==========================================================
   always_comb begin
      st_d = st_q;
      qc_d = qc_q;
      sh_d = sh_q;
      bit_d = bit_q;
      kind_d = kind_q;
      int_left_d = int_left_q;
      rs_done_d = rs_done_q;
      wire_rd_d = wire_rd_q;
      nacked_d = nacked_q;
      scl_low_d = scl_low_q;
      sda_low_d = sda_low_q;
      lost_evt = 1'b0;
      no_acknowledge_flag_set = 1'b0;
      rx_done = 1'b0;
      ack_end = 1'b0;
      thr_load = 1'b0;
      case (st_q)
         two_wire_unit_pkg::s_idle: begin
            // Lines released: no acknowledge, no slave takeover
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
            if (accept) begin
               st_d = two_wire_unit_pkg::s_start;
               qc_d = two_wire_unit_pkg::Q_SETUP;
               rs_done_d = 1'b0;
               int_left_d = quick_q ? two_wire_unit_pkg::INT_ADDR_NONE :
                  internal_address_size;
            end
         end
         two_wire_unit_pkg::s_start: begin
            if (adv) begin
               qc_d = qc_q + 2'h1;
               case (qc_q)
                  two_wire_unit_pkg::Q_SETUP: sda_low_d = 1'b0;
                  two_wire_unit_pkg::Q_RISE: scl_low_d = 1'b0;
                  two_wire_unit_pkg::Q_HIGH: sda_low_d = 1'b1;
                  default: begin
                     scl_low_d = 1'b1;
                     st_d = two_wire_unit_pkg::s_bit;
                     sh_d = addr_byte;
                     wire_rd_d = addr_byte[0];
                     kind_d = two_wire_unit_pkg::K_ADDR;
                     bit_d = 4'h0;
                     nacked_d = 1'b0;
                  end
               endcase
            end
         end
         two_wire_unit_pkg::s_bit: begin
            if (adv) begin
               qc_d = qc_q + 2'h1;
               case (qc_q)
                  two_wire_unit_pkg::Q_SETUP: begin
                     if (bit_q == two_wire_unit_pkg::ACK_SLOT) begin
                        sda_low_d = rd_byte && !stop_req_q;
                     end else begin
                        sda_low_d = !rd_byte && !sh_q[7];
                     end
                  end
                  two_wire_unit_pkg::Q_RISE: scl_low_d = 1'b0;
                  two_wire_unit_pkg::Q_HIGH: begin
                     if (bit_q == two_wire_unit_pkg::ACK_SLOT) begin
                        nacked_d = !rd_byte && sda_s;
                     end else if (rd_byte) begin
                        sh_d = {sh_q[6:0], sda_s};
                     end else if (sh_q[7] && !sda_s) begin
                        lost_evt = 1'b1;
                        st_d = two_wire_unit_pkg::s_lost;
                        sda_low_d = 1'b0;
                        scl_low_d = 1'b0;
                     end
                  end
                  default: begin
                     scl_low_d = 1'b1;
                     if (bit_q != two_wire_unit_pkg::ACK_SLOT) begin
                        bit_d = bit_q + 4'h1;
                        if (!rd_byte) begin
                           sh_d = {sh_q[6:0], 1'b0};
                        end
                        rx_done = rd_byte && (bit_q == two_wire_unit_pkg::LAST_DATA_BIT);
                     end else begin
                        ack_end = 1'b1;
                        bit_d = 4'h0;
                        if (!rd_byte && nacked_q) begin
                           no_acknowledge_flag_set = 1'b1;
                           st_d = two_wire_unit_pkg::s_stop;
                        end else if (quick_q) begin
                           st_d = two_wire_unit_pkg::s_stop;
                        end else if (rd_byte && stop_req_q) begin
                           st_d = two_wire_unit_pkg::s_stop;
                        end else if (kind_q != two_wire_unit_pkg::K_DATA &&
                                     int_left_q != two_wire_unit_pkg::INT_ADDR_NONE) begin
                           sh_d = int_addr_pick(int_left_q, internal_address_bytes);
                           kind_d = two_wire_unit_pkg::K_INT;
                           int_left_d = int_left_q - 2'h1;
                        end else if (kind_q != two_wire_unit_pkg::K_DATA &&
                                     master_direction_bit && !wire_rd_q) begin
                           st_d = two_wire_unit_pkg::s_start;
                           rs_done_d = 1'b1;
                        end else begin
                           kind_d = two_wire_unit_pkg::K_DATA;
                           st_d = two_wire_unit_pkg::s_hold;
                        end
                     end
                  end
               endcase
            end
         end
         two_wire_unit_pkg::s_hold: begin
            qc_d = two_wire_unit_pkg::Q_SETUP;
            if (wire_rd_q) begin
               if (!rhr_full_q) begin
                  st_d = two_wire_unit_pkg::s_bit;
               end
            end else if (thr_full_q) begin
               sh_d = thr_q;
               thr_load = 1'b1;
               st_d = two_wire_unit_pkg::s_bit;
            end else if (stop_req_q) begin
               st_d = two_wire_unit_pkg::s_stop;
            end else begin
               scl_low_d = 1'b1;
            end
         end
         two_wire_unit_pkg::s_stop: begin
            if (adv) begin
               qc_d = qc_q + 2'h1;
               case (qc_q)
                  two_wire_unit_pkg::Q_SETUP: sda_low_d = 1'b1;
                  two_wire_unit_pkg::Q_RISE: scl_low_d = 1'b0;
                  two_wire_unit_pkg::Q_HIGH: sda_low_d = 1'b0;
                  default: st_d = two_wire_unit_pkg::s_idle;
               endcase
            end
         end
         two_wire_unit_pkg::s_lost: begin
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
            if (stop_det) begin
               st_d = two_wire_unit_pkg::s_idle;
            end
         end
         default: st_d = two_wire_unit_pkg::s_idle;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= two_wire_unit_pkg::s_idle;
         qc_q <= two_wire_unit_pkg::Q_SETUP;
         sh_q <= two_wire_unit_pkg::RST_BYTE;
         bit_q <= 4'h0;
         kind_q <= two_wire_unit_pkg::K_ADDR;
         int_left_q <= two_wire_unit_pkg::INT_ADDR_NONE;
         {rs_done_q, wire_rd_q, nacked_q} <= 3'h0;
         {scl_low_q, sda_low_q} <= 2'h0;
      end else begin
         st_q <= st_d;
         qc_q <= qc_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         kind_q <= kind_d;
         int_left_q <= int_left_d;
         {rs_done_q, wire_rd_q, nacked_q} <= {rs_done_d, wire_rd_d, nacked_d};
         {scl_low_q, sda_low_q} <= {scl_low_d, sda_low_d};
      end
   end

   // ==========================================================
   // Requests and status flags (setting beats clearing, except for transmission_complete_flag)
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         {req_q, quick_q, stop_req_q} <= 3'h0;
         {thr_full_q, rhr_full_q} <= 2'h0;
         {noack_q, arb_q} <= 2'h0;
         cmpl_q <= two_wire_unit_pkg::RST_FLAG;
      end else begin
         req_q <= start_evt || (req_q && !accept);
         quick_q <= (quick_cmd && master_enable) || (quick_q && !end_evt);
         stop_req_q <= stop_cmd || (stop_req_q && !end_evt);
         thr_full_q <= thr_write || (thr_full_q && !thr_load);
         rhr_full_q <= rx_done || (rhr_full_q && !rhr_read);
         noack_q <= no_acknowledge_flag_set || (noack_q && !status_read);
         arb_q <= lost_evt || (arb_q && !status_read);
         cmpl_q <= (st_d == two_wire_unit_pkg::s_idle) && !start_evt && !req_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         thr_q <= two_wire_unit_pkg::RST_BYTE;
         rhr_q <= two_wire_unit_pkg::RST_BYTE;
      end else begin
         if (thr_write) begin
            thr_q <= thr_data;
         end
         if (rx_done) begin
            rhr_q <= sh_q;
         end
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign rhr_data = rhr_q;
   assign transmission_complete_flag = cmpl_q;
   assign transmit_ready_flag = !thr_full_q;
   assign receive_ready_flag = rhr_full_q;
   assign no_acknowledge_flag = noack_q;
   assign arbitration_lost_flag = arb_q;
   assign serial_clock_line_out = 1'b0;
   assign serial_clock_line_oe = scl_low_q;
   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe = sda_low_q;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_start_edge;
      (st_q == two_wire_unit_pkg::s_start && adv && qc_q == two_wire_unit_pkg::Q_HIGH)
         |=> (sda_low_q && !scl_low_q);
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start not on high clock");

   property p_lost_release;
      lost_evt |=> (st_q == two_wire_unit_pkg::s_lost && !sda_low_q && !scl_low_q);
   endproperty
   a_lost_release: assert property (p_lost_release) else $error("lines held after loss");

   property p_lost_wait;
      (st_q == two_wire_unit_pkg::s_lost && !stop_det) |=> st_q == two_wire_unit_pkg::s_lost;
   endproperty
   a_lost_wait: assert property (p_lost_wait) else $error("left loss before stop");

   property p_arb_flag;
      lost_evt |=> arbitration_lost_flag [*2];
   endproperty
   a_arb_flag: assert property (p_arb_flag) else $error("arbitration flag missing");

   property p_busy_wait;
      (st_q == two_wire_unit_pkg::s_idle && bus_busy_q) |=> st_q != two_wire_unit_pkg::s_start;
   endproperty
   a_busy_wait: assert property (p_busy_wait) else $error("started on busy bus");

   property p_no_master;
      (st_q == two_wire_unit_pkg::s_idle && !master_enable)
         |=> (st_q == two_wire_unit_pkg::s_idle && !sda_low_q && !scl_low_q);
   endproperty
   a_no_master: assert property (p_no_master) else $error("drove bus while disabled");

   property p_no_acknowledge_flag_stop;
      no_acknowledge_flag_set |=> (no_acknowledge_flag && st_q == two_wire_unit_pkg::s_stop);
   endproperty
   a_no_acknowledge_flag_stop: assert property (p_no_acknowledge_flag_stop) else $error("no stop after no_acknowledge_flag");

   property p_hold_low;
      (st_q == two_wire_unit_pkg::s_hold && !wire_rd_q && !thr_full_q && !stop_req_q)
         ##1 (st_q == two_wire_unit_pkg::s_hold) |-> scl_low_q;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("clock released with no data");

   property p_quick_stop;
      (ack_end && quick_q) |=> st_q == two_wire_unit_pkg::s_stop;
   endproperty
   a_quick_stop: assert property (p_quick_stop) else $error("quick command not stopped");

   property p_stop_edge;
      (st_q == two_wire_unit_pkg::s_stop && adv && qc_q == two_wire_unit_pkg::Q_HIGH)
         |=> (!sda_low_q && !scl_low_q) ##1 st_q == two_wire_unit_pkg::s_stop;
   endproperty
   a_stop_edge: assert property (p_stop_edge) else $error("stop not on high clock");

   c_accept: cover property (accept);
   c_lost: cover property (lost_evt);
   c_rx_byte: cover property (rx_done);
   c_rep_start: cover property (ack_end ##1 st_q == two_wire_unit_pkg::s_start);

endmodule : two_wire_unit_master

// ==== bus_target_model.sv ====
// Behavioural target device on the two-wire bus
`timescale 1ns/1ps
module bus_target_model (
   // Bus
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe,
   // Control and observation
   input wire logic ack_en,
   input wire logic [7:0] rd_byte,
   output logic [7:0] last_byte,
   output logic [7:0] nb
);
   int n = -1;
   logic rd = 1'b0;
   logic first = 1'b1;
   logic [7:0] sh = 8'h00;
   initial sda_oe = 1'b0;
   initial nb = 8'h00;
   // ==========================================
   // Framing
   always @(negedge sda) if (scl) begin
      n = -1;
      rd = 1'b0;
      first = 1'b1;
      nb = 8'h00;
   end
   always @(posedge scl) begin
      if (n < 8) sh = {sh[6:0], sda};
      else if (sda) rd = 1'b0;
   end
   always @(negedge scl) begin
      n = n + 1;
      if (n == 8) begin
         last_byte = sh;
         nb = nb + 8'h01;
         if (first) rd = sh[0];
      end
      if (n == 9) begin
         n = 0;
         first = 1'b0;
      end
      if (n == 8) sda_oe = ack_en && !(rd && !first);
      else sda_oe = rd && !first && !rd_byte[7 - n];
   end
endmodule : bus_target_model

// ==== two_wire_unit_master_test.sv ====
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
module two_wire_unit_master_test;
   // ==========================================
   // Signals
   logic clk, rst, me, dir, stc, spc, qc, thw, rr, sr, ack_en, arb_oe;
   logic [6:0] addr;
   logic [1:0] isz;
   logic [7:0] rhd, lb, nb;
   logic tc, tr, rxr, nk, al, sco, scoe, sdo, sdoe, t_oe;
   wire logic scl = !scoe;
   wire logic sda = !(sdoe || t_oe || arb_oe);
   int mismatches = 0;
   int n_checks = 0;
   typedef struct packed {logic [1:0] k; logic [6:0] a; logic [1:0] s; logic [7:0] nbx;
      logic [7:0] lx;} row_t;
   row_t rows [8] = '{'{2'h0, 7'h50, 2'h0, 8'h02, 8'h5e}, '{2'h0, 7'h50, 2'h1, 8'h03, 8'h5e},
      '{2'h0, 7'h50, 2'h2, 8'h04, 8'h5e}, '{2'h0, 7'h50, 2'h3, 8'h05, 8'h5e},
      '{2'h0, 7'h79, 2'h1, 8'h03, 8'h5e}, '{2'h1, 7'h50, 2'h0, 8'h02, 8'hc3},
      '{2'h1, 7'h50, 2'h3, 8'h02, 8'hc3}, '{2'h2, 7'h50, 2'h0, 8'h01, 8'ha0}};
   two_wire_unit_master #(.QUARTER_CYC(4)) two_wire_unit_master_inst (
      .ref_clk(clk), .sys_rst(rst), .master_enable(me), .target_device_address(addr),
      .internal_address_size(isz), .internal_address_bytes(24'h1a2b3c),
      .master_direction_bit(dir), .start_cmd(stc), .stop_cmd(spc), .quick_cmd(qc),
      .thr_write(thw), .thr_data(8'h5e), .rhr_read(rr), .status_read(sr), .rhr_data(rhd),
      .transmission_complete_flag(tc), .transmit_ready_flag(tr), .receive_ready_flag(rxr),
      .no_acknowledge_flag(nk), .arbitration_lost_flag(al), .serial_clock_line_in(scl),
      .serial_clock_line_out(sco), .serial_clock_line_oe(scoe), .serial_data_line_in(sda),
      .serial_data_line_out(sdo), .serial_data_line_oe(sdoe));
   bus_target_model bus_target_model_inst (.scl(scl), .sda(sda), .sda_oe(t_oe),
      .ack_en(ack_en), .rd_byte(8'hc3), .last_byte(lb), .nb(nb));
   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic go(input logic [5:0] v);
      @(posedge clk);
      {stc, spc, qc, thw, rr, sr} <= v;
      @(posedge clk);
      {stc, spc, qc, thw, rr, sr} <= 6'h00;
      @(posedge clk);
   endtask : go
   task automatic wdone();
      int j;
      repeat (4) @(posedge clk);
      for (j = 0; j < 4000 && tc !== 1'b1; j++) @(posedge clk);
      chk("complete", tc, 8'h01);
   endtask : wdone
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   // ==========================================
   // Clock, reset, watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      test_done();
   end
   // ==========================================
   // Tests
   initial begin
      {rst, me, dir, stc, spc, qc, thw, rr, sr, arb_oe} = 10'h200;
      ack_en = 1'b1;
      addr = 7'h50;
      isz = 2'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("idle", {tc, tr, scoe, sdoe, al, nk}, 8'h30);
      chk("pin levels", {sco, sdo}, 8'h00);
      go(6'h20);
      repeat (50) @(posedge clk);
      chk("disabled", {scoe, sdoe}, 8'h00);
      me <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         addr <= rows[i].a;
         isz <= rows[i].s;
         dir <= (rows[i].k == 2'h1);
         go({rows[i].k == 2'h1, rows[i].k != 2'h2, rows[i].k == 2'h2, rows[i].k == 2'h0, 2'h0});
         wdone();
         chk("bytes", nb, rows[i].nbx);
         chk("last", lb, rows[i].lx);
         chk("no_acknowledge_flag", nk, 8'h00);
         if (rows[i].k == 2'h1) begin
            chk("rx ready", rxr, 8'h01);
            chk("rhr", rhd, 8'hc3);
            go(6'h02);
         end
      end
      addr <= 7'h50;
      isz <= 2'h0;
      dir <= 1'b0;
      // Write with no stop: clock held low after the byte
      go(6'h04);
      repeat (400) @(posedge clk);
      chk("held", {scoe, tc}, 8'h02);
      go(6'h10);
      wdone();
      chk("held bytes", nb, 8'h02);
      // Two-byte read, last byte closed by software
      dir <= 1'b1;
      go(6'h20);
      for (int i = 0; i < 2000 && rxr !== 1'b1; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      go(6'h10);
      chk("first rx", rhd, 8'hc3);
      go(6'h02);
      for (int i = 0; i < 2000 && rxr !== 1'b1; i++) @(posedge clk);
      chk("last ready", rxr, 8'h01);
      chk("last rx", rhd, 8'hc3);
      go(6'h02);
      wdone();
      chk("rx bytes", nb, 8'h03);
      chk("rx no_acknowledge_flag", nk, 8'h00);
      dir <= 1'b0;
      ack_en <= 1'b0;
      go(6'h14);
      wdone();
      chk("no_acknowledge_flag set", nk, 8'h01);
      chk("no_acknowledge_flag bytes", nb, 8'h01);
      ack_en <= 1'b1;
      go(6'h01);
      chk("no_acknowledge_flag clr", nk, 8'h00);
      arb_oe <= 1'b1;
      repeat (8) @(posedge clk);
      go(6'h14);
      repeat (200) @(posedge clk);
      chk("busy wait", {scoe, tc}, 8'h00);
      arb_oe <= 1'b0;
      wdone();
      chk("after busy", nb, 8'h02);
      go(6'h14);
      for (int i = 0; i < 100 && scoe !== 1'b1; i++) @(posedge clk);
      arb_oe <= 1'b1;
      repeat (100) @(posedge clk);
      chk("lost", {al, scoe, sdoe, tc}, 8'h08);
      arb_oe <= 1'b0;
      wdone();
      chk("lost idle", {al, scoe, sdoe}, 8'h04);
      go(6'h01);
      chk("lost clr", al, 8'h00);
      test_done();
   end
endmodule : two_wire_unit_master_test
